/* File: design/lcc_regs.vh */
// Register map, field positions, reset values and timing of the charge sequencer.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCC_ADDR_INPUT_CURRENT_LIMIT 8'h02
`define LCC_ADDR_CTRL 8'h04
`define LCC_ADDR_TIMER 8'h05
`define LCC_ADDR_STATUS 8'h0b
`define LCC_ADDR_FAULT 8'h0d

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LCC_CTRL_CHG 0
`define LCC_CTRL_TRK 1
`define LCC_CTRL_KICK 2
`define LCC_CTRL_RESET 2'h3

// ----------------------------------------
// Fault register fields (write one to clear)
// ----------------------------------------
`define LCC_FLT_TRK 0
`define LCC_FLT_FAST 1
`define LCC_FLT_SAFE 2
`define LCC_FLT_TSD 3
`define LCC_FLT_WARN 4

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LCC_STAT_DONE 3
`define LCC_STAT_ISO 4
`define LCC_STAT_WD 5
`define LCC_STAT_SAFE 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCC_INPUT_CURRENT_LIMIT_RESET 4'h0
`define LCC_TIMER_RESET 8'h00

// ----------------------------------------
// Charger state codes
// ----------------------------------------
`define LCC_ST_OFF 3'h0
`define LCC_ST_TRK 3'h1
`define LCC_ST_CC 3'h2
`define LCC_ST_CV 3'h3
`define LCC_ST_DONE 3'h4
`define LCC_ST_WEAK 3'h5
`define LCC_ST_FAULT 3'h6

// ----------------------------------------
// Timing: clock period and second tick
// ----------------------------------------
`define LCC_CLK_NS 100
`define LCC_SEC_NS 1000000000
`define LCC_SEC_CYC (`LCC_SEC_NS / `LCC_CLK_NS)
// Long timers in minutes and seconds
`define LCC_TRK_MIN 60
`define LCC_TRK_S (`LCC_TRK_MIN * 60)
`define LCC_FAST_MIN 60
`define LCC_SAFE_MIN 40
`define LCC_SAFE_S (`LCC_SAFE_MIN * 60)
`define LCC_WD_S 32
`define LCC_END_S 30

`endif

/* File: design/lcc_sync3.v */
// Three-stage synchroniser with agreement filter for asynchronous level inputs.
// Assumes inputs are slow levels from comparators or pins; output lags by four edges.
module lcc_sync3 #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire rstn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // First stage feeds only the second; output moves once stages two and three agree
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // lcc_sync3

/* File: design/lcc_charge_ctrl.v */
// Charge state sequencer of a single-cell lithium-ion switch-mode charger.
// Assumes comparator levels arrive asynchronously and register accesses come
// already decoded from the management bus slave, one cycle per access.
//
// How it works
// - Cell below dead threshold charges in trickle, state code shows trickle.
// - Trickle lasting over 60 minutes stops charging as a fault.
// - Trickle timeout fault shows in the state code for recovery.
// - Between dead and weak thresholds the weak constant-current mode runs.
// - Weak mode forces the input current limit to 100 mA.
// - Weak mode drives 20 mA through the linear trickle branch.
// - Above both thresholds fast constant current runs and is reported.
// - At termination voltage enter constant voltage and report it.
// - Fast timeout before termination voltage stops charging with a fault.
// - Fast timeout in constant voltage stops without fault, resumes on recharge.
// - Watchdog starts on first kick or cell above weak threshold.
// - Watchdog expiry during charging starts the safety timer.
// - Safety timer restores default limit, charges its period, then stops.
// - Current below end level for end time completes charge, sets done.
// - After completion, recharge threshold restarts charging in constant voltage.
// - Charging is disabled while the enable bit is low.
// - While charging, at the isothermal limit current is limited and the flag raised.
// - Above shutdown temperature the charger stops and the flag sets.
// - Restart needs temperature below falling limit and flag cleared at 0x0d.
// - Early warning flag sets between the warning and shutdown temperatures.
// - Fault shows as code 110; writing ones to fault bits recovers.
`include "lcc_regs.vh"

module lcc_charge_ctrl #(
  parameter SEC_CYC = `LCC_SEC_CYC
) (
  input wire ref_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  input wire cell_above_dead,
  input wire cell_above_weak,
  input wire term_reached,
  input wire current_below_end,
  input wire at_recharge_level,
  input wire die_at_iso_limit,
  input wire die_above_shutdown,
  input wire die_below_falling,
  input wire die_above_warning,
  input wire trickle_control_pin,
  output reg [2:0] charger_state,
  output reg [3:0] input_current_limit,
  output reg trickle_branch_on,
  output reg switcher_on,
  output reg cv_regulate,
  output reg charge_finished_flag,
  output reg isothermal_active_flag,
  output reg die_overheat_flag
);

  // ----------------------------------------
  // Synchronised comparator levels
  // ----------------------------------------
  wire [9:0] lvl;
  lcc_sync3 #(
    .W(10)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({trickle_control_pin, die_above_warning, die_below_falling,
          die_above_shutdown, die_at_iso_limit, at_recharge_level,
          current_below_end, term_reached, cell_above_weak, cell_above_dead}),
    .dout(lvl)
  );
  wire above_dead = lvl[0];
  wire above_weak = lvl[1];
  wire at_term = lvl[2];
  wire below_end = lvl[3];
  wire at_rch = lvl[4];
  wire die_lim = lvl[5];
  wire die_sd = lvl[6];
  wire die_fall = lvl[7];
  wire die_warn = lvl[8];
  wire trk_pin = lvl[9];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] ctrl_r;
  reg trk_written_r;
  reg [3:0] input_current_limit_r;
  reg [7:0] timer_r;
  reg [4:0] fault_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg done_r;
  reg wd_run_r;
  reg safe_run_r;
  reg [23:0] pre_r;
  reg [15:0] trk_s_r;
  reg [15:0] fast_s_r;
  reg [15:0] wd_s_r;
  reg [15:0] safe_s_r;
  reg [15:0] end_s_r;
  reg [15:0] fast_lim;
  reg [15:0] wd_lim;

  // Limits kept as integers, cut to the counter widths where they are used
  localparam integer SEC_LAST = SEC_CYC - 1;
  localparam integer FAST_BASE = `LCC_FAST_MIN * 60;
  localparam integer WD_BASE = `LCC_WD_S;
  localparam integer TRK_LIM = `LCC_TRK_S;
  localparam integer SAFE_LIM = `LCC_SAFE_S;
  localparam integer END_LIM = `LCC_END_S;

  wire wr_ctrl = reg_wr && (reg_addr == `LCC_ADDR_CTRL);
  wire kick = wr_ctrl && reg_wdata[`LCC_CTRL_KICK];
  wire wr_fault = reg_wr && (reg_addr == `LCC_ADDR_FAULT);
  wire sec_tick = (pre_r == SEC_LAST[23:0]);

  // Trickle allowed: pin low enables until software writes its own bit
  wire trk_allow = trk_written_r ? ctrl_r[`LCC_CTRL_TRK] : !trk_pin;
  wire hard_fault = fault_r[`LCC_FLT_TRK] | fault_r[`LCC_FLT_FAST] | fault_r[`LCC_FLT_SAFE];
  // Restart only once the overheat flag is cleared and the die has cooled
  wire thermal_ok = !fault_r[`LCC_FLT_TSD] && !die_sd && die_fall;
  wire chg_en = ctrl_r[`LCC_CTRL_CHG] && thermal_ok;
  wire charging = (state_r == `LCC_ST_TRK) || (state_r == `LCC_ST_WEAK) ||
                  (state_r == `LCC_ST_CC) || (state_r == `LCC_ST_CV);
  wire in_fast = (state_r == `LCC_ST_CC) || (state_r == `LCC_ST_CV);

  // Timer limits from the timer configuration register
  always @* begin
    case (timer_r[1:0])
      2'h0: fast_lim = FAST_BASE[15:0];
      2'h1: fast_lim = FAST_BASE[15:0] * 16'h0002;
      2'h2: fast_lim = FAST_BASE[15:0] * 16'h0003;
      default: fast_lim = FAST_BASE[15:0] * 16'h0004;
    endcase
    wd_lim = timer_r[2] ? WD_BASE[15:0] * 16'h0002 : WD_BASE[15:0];
  end

  wire trk_expired = (trk_s_r >= TRK_LIM[15:0]);
  wire fast_expired = (fast_s_r >= fast_lim);
  wire wd_expired = wd_run_r && (wd_s_r >= wd_lim);
  wire safe_expired = safe_run_r && (safe_s_r >= SAFE_LIM[15:0]);
  wire end_reached = (end_s_r >= END_LIM[15:0]);

  // ----------------------------------------
  // Register writes and one-second prescaler
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `LCC_CTRL_RESET;
      trk_written_r <= 1'b0;
      input_current_limit_r <= `LCC_INPUT_CURRENT_LIMIT_RESET;
      timer_r <= `LCC_TIMER_RESET;
      pre_r <= 24'h000000;
    end else begin
      pre_r <= sec_tick ? 24'h000000 : pre_r + 24'h000001;
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[1:0];
        trk_written_r <= 1'b1;
      end
      if (reg_wr && (reg_addr == `LCC_ADDR_TIMER)) begin
        timer_r <= reg_wdata;
      end
      // Safety start returns the limit to default; a later write still wins
      if (reg_wr && (reg_addr == `LCC_ADDR_INPUT_CURRENT_LIMIT)) begin
        input_current_limit_r <= reg_wdata[3:0];
      end else if (wd_expired && charging && !safe_run_r) begin
        input_current_limit_r <= `LCC_INPUT_CURRENT_LIMIT_RESET;
      end
    end
  end

  // ----------------------------------------
  // Fault flags: hardware set beats software clear
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_r <= 5'h00;
    end else begin
      fault_r <= (fault_r & ~(wr_fault ? reg_wdata[4:0] : 5'h00)) |
        {die_warn && !die_sd,
         die_sd,
         safe_expired && charging,
         fast_expired && state_r == `LCC_ST_CC,
         trk_expired && state_r == `LCC_ST_TRK};
    end
  end

  // ----------------------------------------
  // Charge state machine
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `LCC_ST_OFF: begin
        if (!above_dead) begin
          state_nxt = trk_allow ? `LCC_ST_TRK : `LCC_ST_OFF;
        end else if (!above_weak) begin
          state_nxt = `LCC_ST_WEAK;
        end else if (at_term) begin
          state_nxt = `LCC_ST_CV;
        end else begin
          state_nxt = `LCC_ST_CC;
        end
      end
      `LCC_ST_TRK: begin
        if (trk_expired) begin
          state_nxt = `LCC_ST_FAULT;
        end else if (above_dead) begin
          state_nxt = above_weak ? `LCC_ST_CC : `LCC_ST_WEAK;
        end
      end
      `LCC_ST_WEAK: begin
        if (!above_dead) begin
          state_nxt = `LCC_ST_TRK;
        end else if (above_weak) begin
          state_nxt = `LCC_ST_CC;
        end
      end
      `LCC_ST_CC: begin
        if (fast_expired) begin
          state_nxt = `LCC_ST_FAULT;
        end else if (at_term) begin
          state_nxt = `LCC_ST_CV;
        end
      end
      `LCC_ST_CV: begin
        if (end_reached || fast_expired) begin
          state_nxt = `LCC_ST_DONE;
        end
      end
      `LCC_ST_DONE: begin
        if (at_rch) begin
          state_nxt = `LCC_ST_CV;
        end
      end
      `LCC_ST_FAULT: begin
        if (!hard_fault) begin
          state_nxt = `LCC_ST_OFF;
        end
      end
      default: state_nxt = `LCC_ST_OFF;
    endcase
    // Disable and faults override every sequencing step
    if (hard_fault || (safe_expired && charging)) begin
      state_nxt = `LCC_ST_FAULT;
    end else if (!chg_en) begin
      state_nxt = `LCC_ST_OFF;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= `LCC_ST_OFF;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == `LCC_ST_CV && end_reached) begin
        done_r <= 1'b1;
      end else if (state_nxt != `LCC_ST_DONE) begin
        done_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Second-based timers
  // ----------------------------------------
  // Trickle and fast timers restart on leaving their phase
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trk_s_r <= 16'h0000;
      fast_s_r <= 16'h0000;
      end_s_r <= 16'h0000;
    end else begin
      if (state_r != `LCC_ST_TRK) begin
        trk_s_r <= 16'h0000;
      end else if (sec_tick && !trk_expired) begin
        trk_s_r <= trk_s_r + 16'h0001;
      end
      if (!in_fast) begin
        fast_s_r <= 16'h0000;
      end else if (sec_tick && !fast_expired) begin
        fast_s_r <= fast_s_r + 16'h0001;
      end
      // Current rising above end level restarts the end timer
      if (state_r != `LCC_ST_CV || !below_end) begin
        end_s_r <= 16'h0000;
      end else if (sec_tick && !end_reached) begin
        end_s_r <= end_s_r + 16'h0001;
      end
    end
  end

  // Watchdog and safety timers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_run_r <= 1'b0;
      wd_s_r <= 16'h0000;
      safe_run_r <= 1'b0;
      safe_s_r <= 16'h0000;
    end else begin
      if (kick || above_weak) begin
        wd_run_r <= 1'b1;
      end
      if (kick) begin
        wd_s_r <= 16'h0000;
      end else if (wd_run_r && sec_tick && !wd_expired) begin
        wd_s_r <= wd_s_r + 16'h0001;
      end
      if (wd_expired && charging) begin
        safe_run_r <= 1'b1;
      end else if (state_r == `LCC_ST_FAULT && !hard_fault) begin
        safe_run_r <= 1'b0;
      end
      if (!safe_run_r) begin
        safe_s_r <= 16'h0000;
      end else if (sec_tick && !safe_expired) begin
        safe_s_r <= safe_s_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Outputs and read data
  // ----------------------------------------
  // Weak mode caps input at the default 100 mA code whatever the limit register holds
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      charger_state <= `LCC_ST_OFF;
      input_current_limit <= `LCC_INPUT_CURRENT_LIMIT_RESET;
      trickle_branch_on <= 1'b0;
      switcher_on <= 1'b0;
      cv_regulate <= 1'b0;
      charge_finished_flag <= 1'b0;
      isothermal_active_flag <= 1'b0;
      die_overheat_flag <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      charger_state <= state_r;
      input_current_limit <= (state_r == `LCC_ST_WEAK) ? `LCC_INPUT_CURRENT_LIMIT_RESET : input_current_limit_r;
      trickle_branch_on <= (state_r == `LCC_ST_TRK) || (state_r == `LCC_ST_WEAK);
      switcher_on <= (state_r == `LCC_ST_WEAK) || in_fast;
      cv_regulate <= (state_r == `LCC_ST_CV);
      charge_finished_flag <= done_r;
      isothermal_active_flag <= charging && die_lim;
      die_overheat_flag <= fault_r[`LCC_FLT_TSD];
      case (reg_addr)
        `LCC_ADDR_INPUT_CURRENT_LIMIT: reg_rdata <= {4'h0, input_current_limit_r};
        `LCC_ADDR_CTRL: reg_rdata <= {6'h00, ctrl_r};
        `LCC_ADDR_TIMER: reg_rdata <= timer_r;
        `LCC_ADDR_STATUS: reg_rdata <= {1'b0, safe_run_r, wd_run_r,
                                       charging && die_lim, done_r, state_r};
        `LCC_ADDR_FAULT: reg_rdata <= {3'h0, fault_r};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // lcc_charge_ctrl

/* File: tb/lcc_charge_ctrl_assertions.sv */
// Output relations of the charge sequencer, checked at its ports.
// Assumes binding to lcc_charge_ctrl; one clock, reset active low.
module lcc_charge_ctrl_chk (
  input wire ref_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [2:0] charger_state,
  input wire [3:0] input_current_limit,
  input wire trickle_branch_on,
  input wire switcher_on,
  input wire cv_regulate,
  input wire charge_finished_flag,
  input wire isothermal_active_flag,
  input wire die_overheat_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------
  // State and output relations
  // ------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_trickle_out: assert property (
    charger_state == 3'h1 |-> trickle_branch_on && !switcher_on) else $error("trickle outputs");
  a_weak_limit: assert property (
    charger_state == 3'h5 |-> input_current_limit == 4'h0) else $error("weak limit");
  a_weak_branch: assert property (
    charger_state == 3'h5 |-> trickle_branch_on && switcher_on) else $error("weak outputs");
  a_fast_cc: assert property (
    charger_state == 3'h2 |-> switcher_on && !cv_regulate) else $error("cc outputs");
  a_cv_hold: assert property (
    charger_state == 3'h3 |-> switcher_on && cv_regulate) else $error("cv outputs");
  a_fault_stop: assert property (
    charger_state == 3'h6 |-> !switcher_on && !trickle_branch_on) else $error("fault outputs");
  // Enable low must reach OFF within the control register, state and output latency
  a_disable_off: assert property (
    reg_wr && reg_addr == 8'h04 && !reg_wdata[0] |-> ##[1:8] charger_state == 3'h0)
    else $error("disable ignored");
  // Outputs must be stopped once the flag has held six cycles; the outputs drop on the same edge as the flag rises
  a_overheat_stop: assert property (
    die_overheat_flag [*6] |-> !switcher_on && !trickle_branch_on) else $error("hot charging");
  a_done_complete: assert property (
    $rose(charge_finished_flag) |-> ##[0:2] charger_state == 3'h4) else $error("done state");
  a_iso_charging: assert property (
    $rose(isothermal_active_flag) |-> switcher_on || trickle_branch_on) else $error("iso idle");
  a_state_legal: assert property (
    charger_state != 3'h7) else $error("state code");
  c_done: cover property (charger_state == 3'h4 && charge_finished_flag);
  c_fault: cover property (charger_state == 3'h6);
  c_hot: cover property (die_overheat_flag && charger_state == 3'h0);
endmodule // lcc_charge_ctrl_chk

bind lcc_charge_ctrl lcc_charge_ctrl_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .charger_state(charger_state),
  .input_current_limit(input_current_limit), .trickle_branch_on(trickle_branch_on),
  .switcher_on(switcher_on), .cv_regulate(cv_regulate),
  .charge_finished_flag(charge_finished_flag), .isothermal_active_flag(isothermal_active_flag),
  .die_overheat_flag(die_overheat_flag));

/* File: tb/lcc_host_model.sv */
// Host processor model on the decoded register port of the sequencer.
// Assumes one clock; bus changes only just after rising edges.
module lcc_host_model (
  input wire ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lk = 1'b0;
  logic kick_en = 1'b0;
  logic [7:0] ctl = 8'h03;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end
  // ------------
  // Bus access
  // ------------
  // Lock, since kicker and bench share one port
  task automatic grab();
    while (lk) @(posedge ref_clk);
    lk = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    grab();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // Stale data must not look valid
    lk = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    grab();
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
    lk = 1'b0;
  endtask
  task automatic setctl(input logic [7:0] v);
    ctl = v;
    wr(8'h04, v);
  endtask
  // Kick well inside the 128-cycle watchdog period
  always begin
    repeat (60) @(posedge ref_clk);
    if (kick_en) wr(8'h04, ctl | 8'h04);
  end
endmodule // lcc_host_model

/* File: tb/lcc_charge_ctrl_test.sv */
// Self-checking bench of the charge sequencer with a host model.
// Assumes SEC_CYC of 4, so every timer second is four clocks.
module lcc_charge_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cell_above_dead = 1'b0, cell_above_weak = 1'b0, term_reached = 1'b0;
  logic current_below_end = 1'b0, at_recharge_level = 1'b0, die_at_iso_limit = 1'b0;
  logic die_above_shutdown = 1'b0, die_below_falling = 1'b1, die_above_warning = 1'b0;
  logic trickle_control_pin = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, trickle_branch_on, switcher_on, cv_regulate;
  wire charge_finished_flag, isothermal_active_flag, die_overheat_flag;
  wire [2:0] charger_state;
  wire [3:0] input_current_limit;
  int err_total = 0;
  int cmp_count = 0;
  int i;
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  lcc_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata));
  lcc_charge_ctrl #(.SEC_CYC(4)) dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .cell_above_dead(cell_above_dead), .cell_above_weak(cell_above_weak),
    .term_reached(term_reached), .current_below_end(current_below_end),
    .at_recharge_level(at_recharge_level), .die_at_iso_limit(die_at_iso_limit),
    .die_above_shutdown(die_above_shutdown), .die_below_falling(die_below_falling),
    .die_above_warning(die_above_warning), .trickle_control_pin(trickle_control_pin),
    .charger_state(charger_state), .input_current_limit(input_current_limit),
    .trickle_branch_on(trickle_branch_on), .switcher_on(switcher_on),
    .cv_regulate(cv_regulate), .charge_finished_flag(charge_finished_flag),
    .isothermal_active_flag(isothermal_active_flag), .die_overheat_flag(die_overheat_flag));
  // ------------
  // Helpers
  // ------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait for a state code; running out shows as a mismatch
  task automatic wst(input logic [2:0] s, input int n);
    for (i = 0; i < n && charger_state !== s; i++) cyc(1);
    chk(charger_state, s);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d & m, e);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_regs();
    rdm(8'h04, 8'hff, 8'h03);
    host.wr(8'h02, 8'h05);
    rdm(8'h02, 8'hff, 8'h05);
    host.wr(8'h05, 8'h05);
    rdm(8'h05, 8'hff, 8'h05);
    host.wr(8'h05, 8'h00);
    rdm(8'h33, 8'hff, 8'h00);
    rdm(8'h0b, 8'h20, 8'h00);
  endtask
  task automatic t_trickle();
    wst(3'h1, 20);
    chk(trickle_branch_on, 1'b1);
    cyc(14000);
    chk(charger_state, 3'h1);
    wst(3'h6, 800);
    rdm(8'h0d, 8'h07, 8'h01);
  endtask
  task automatic t_weak();
    cell_above_dead = 1'b1;
    host.wr(8'h0d, 8'h01);
    wst(3'h5, 30);
    chk(input_current_limit, 4'h0);
    chk(trickle_branch_on & switcher_on, 1'b1);
    host.wr(8'h04, 8'h07);
    rdm(8'h0b, 8'h20, 8'h20);
    host.kick_en = 1'b1;
  endtask
  task automatic t_fast();
    cell_above_weak = 1'b1;
    wst(3'h2, 20);
    chk(input_current_limit, 4'h5);
    term_reached = 1'b1;
    wst(3'h3, 20);
    chk(cv_regulate, 1'b1);
    current_below_end = 1'b1;
    cyc(80);
    current_below_end = 1'b0;
    cyc(60);
    current_below_end = 1'b1;
    cyc(100);
    chk(charger_state, 3'h3);
    wst(3'h4, 40);
    chk(charge_finished_flag, 1'b1);
    current_below_end = 1'b0;
    at_recharge_level = 1'b1;
    wst(3'h3, 20);
    at_recharge_level = 1'b0;
  endtask
  task automatic t_cvtime();
    wst(3'h4, 15000);
    chk(charge_finished_flag, 1'b0);
    rdm(8'h0d, 8'h02, 8'h00);
    at_recharge_level = 1'b1;
    wst(3'h3, 20);
    at_recharge_level = 1'b0;
  endtask
  task automatic t_cctime();
    // Drop termination first so the level has settled before re-enable
    term_reached = 1'b0;
    host.setctl(8'h02);
    wst(3'h0, 20);
    chk(switcher_on, 1'b0);
    cyc(4);
    host.setctl(8'h03);
    wst(3'h2, 20);
    wst(3'h6, 15000);
    rdm(8'h0d, 8'h02, 8'h02);
    host.wr(8'h0d, 8'h02);
    wst(3'h2, 30);
  endtask
  task automatic t_thermal();
    die_at_iso_limit = 1'b1;
    cyc(8);
    chk(isothermal_active_flag, 1'b1);
    die_at_iso_limit = 1'b0;
    die_above_warning = 1'b1;
    cyc(8);
    rdm(8'h0d, 8'h10, 8'h10);
    die_above_shutdown = 1'b1;
    die_below_falling = 1'b0;
    wst(3'h0, 20);
    chk(die_overheat_flag, 1'b1);
    die_above_shutdown = 1'b0;
    host.wr(8'h0d, 8'h18);
    cyc(20);
    chk(charger_state, 3'h0);
    die_below_falling = 1'b1;
    die_above_warning = 1'b0;
    host.wr(8'h0d, 8'h18);
    wst(3'h2, 30);
    chk(die_overheat_flag, 1'b0);
  endtask
  task automatic t_safety();
    host.wr(8'h02, 8'h07);
    host.kick_en = 1'b0;
    cyc(2);
    chk(input_current_limit, 4'h7);
    for (i = 0; i < 300 && input_current_limit !== 4'h0; i++) cyc(1);
    chk(input_current_limit, 4'h0);
    rdm(8'h0b, 8'h40, 8'h40);
    chk(charger_state, 3'h2);
    wst(3'h6, 9800);
    rdm(8'h0d, 8'h04, 8'h04);
  endtask
  // ------------
  // Main sequence and watchdog
  // ------------
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    chk(charger_state, 3'h0);
    rstn = 1'b1;
    t_regs();
    t_trickle();
    t_weak();
    t_fast();
    t_cvtime();
    t_cctime();
    t_thermal();
    t_safety();
    close_out();
  end
  // Roughly 55k cycles expected; cut off at 80k
  initial begin
    #8000000;
    err_total++;
    close_out();
  end
endmodule // lcc_charge_ctrl_test
